// file: hw/icp_pkg.sv
/*
  Constants and carrier types for the input port and chip-select port.
  Assumes a 32-bit APB master; each register is one aligned word whose
  byte address is four times its printed index.
*/
package icp_pkg;

  localparam int ADDR_W = 22;
  localparam int LVL_W  = 8;
  localparam int CSP_W  = 5;
  localparam int CS_N_W = 4;
  localparam int IRQ_W  = 4;

  localparam logic [19:0] DIR_IDX = 20'hee007;
  localparam logic [19:0] LVL_IDX = 20'hfffd6;
  localparam logic [19:0] DAT_IDX = 20'hfffd7;

  localparam logic [ADDR_W-1:0] DIR_ADDR = {DIR_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] LVL_ADDR = {LVL_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] DAT_ADDR = {DAT_IDX, 2'b00};

  localparam logic [7:0] DIR_RST    = 8'hf0;
  localparam logic [7:0] DAT_RST    = 8'he0;
  localparam logic [7:0] RSVD_ONES  = 8'he0;
  localparam logic [7:0] DIR_RDBACK = 8'hff;

  localparam int PIN_REFRESH_STROBE_OUT = 0;
  localparam int PIN_CS3  = 1;
  localparam int PIN_CS2  = 2;
  localparam int PIN_CS1  = 3;
  localparam int PIN_CS0  = 4;
  localparam int PIN_TRIG = 3;
  localparam int DRAS_HI  = 2;

  typedef enum logic [1:0] {
    ICP_IDLE   = 2'b01,
    ICP_ANSWER = 2'b10
  } icp_state_t;

  typedef struct packed {
    logic [CSP_W-1:0] out;
    logic [CSP_W-1:0] oe_n;
  } icp_pins_t;

  typedef struct packed {
    logic [CS_N_W-1:0] cs_n;
    logic [1:0]        row_strobe_n;
    logic              refresh_strobe_out;
    logic              refresh_strobe_enable;
    logic [2:0]        dram_area_select;
  } icp_ctl_t;

endpackage

// file: hw/icp_ports.sv
/*
  APB register slave and pin logic for an 8-bit input-only port and a
  5-bit bidirectional port shared with chip selects, DRAM strobes,
  external interrupt inputs and a converter trigger.
  Assumes pin inputs are asynchronous, bus controller signals share pclk,
  and pad logic resolves each pin from out and active-low oe_n.
*/
// Local design decision: the APB slave port.
`timescale 1ns/1ns

// Overview of operation
// - Input port is eight input-only pins, same in every mode.
// - Input port reads return synchronised pin levels; writes do nothing.
// - Direction register is write-only; reads return all ones.
// - Direction bits 7 to 5 are fixed at one.
// - Direction bits 4 to 1 set make pins 4 to 1 chip selects 0 to 3.
// - Direction bit cleared makes its pin an input.
// - After reset pin 4 drives chip select 0; pins 3 to 1 are inputs.
// - Refresh enable set makes pin 0 output the refresh strobe.
// - Refresh enable clear leaves pin 0 to its direction bit.
// - Reset and hardware standby load direction with f0; else kept.
// - In software standby output pins keep driving their level.
// - Data register drives pins set as general-purpose outputs.
// - Data bit with direction one reads the stored bit.
// - Data bit with direction zero reads the pin level.
// - Data bits 7 to 5 are fixed and read as one.
// - Reset and hardware standby load data with e0; else kept.
// - Interrupt requests follow enable bits whatever the pin direction.
// - With DRAM in areas 2 to 5, chip selects 3 and 2 carry RAS.
module icp_ports #(
  parameter int ADDR_W = icp_pkg::ADDR_W
) (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [ADDR_W-1:0]         paddr,
  input  wire logic [31:0]               pwdata,
  input  wire logic [3:0]                pstrb,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic [icp_pkg::LVL_W-1:0] level_pins_in,
  input  wire logic [icp_pkg::CSP_W-1:0] cs_port_in,
  output icp_pkg::icp_pins_t             cs_port_drive,
  input  wire icp_pkg::icp_ctl_t         bus_ctl,
  input  wire logic [icp_pkg::IRQ_W-1:0] interrupt_enable_bits,
  input  wire logic                      hw_standby_in,
  output logic      [icp_pkg::IRQ_W-1:0] irq_request,
  output logic                           converter_trigger_in
);

  if (ADDR_W < icp_pkg::ADDR_W) begin : g_bad_width
    $error("Address width too small for the register map.");
  end

  localparam int CW = icp_pkg::CSP_W;

  logic [icp_pkg::LVL_W-1:0] lvl_s1;
  logic [icp_pkg::LVL_W-1:0] lvl_s2;
  logic [CW-1:0]             csp_s1;
  logic [CW-1:0]             csp_s2;
  logic                      hws_s1;
  logic                      hws_s2;
  logic [CW-1:0]             dir;
  logic [CW-1:0]             dat;
  icp_pkg::icp_state_t       state;
  logic [31:0]               next_prdata;
  logic                      next_pslverr;
  icp_pkg::icp_pins_t        next_drive;
  logic                      setup;
  logic                      wr_en;
  logic [CW-1:0]             dat_view;
  logic                      dram_any;

  // Pin inputs pass two flip-flops before any logic looks at them.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl_s1 <= '0;
      lvl_s2 <= '0;
      // Port pins idle high, so no false trigger or request follows reset.
      csp_s1 <= '1;
      csp_s2 <= '1;
      hws_s1 <= 1'b0;
      hws_s2 <= 1'b0;
    end else begin
      lvl_s1 <= level_pins_in;
      lvl_s2 <= lvl_s1;
      csp_s1 <= cs_port_in;
      csp_s2 <= csp_s1;
      hws_s1 <= hw_standby_in;
      hws_s2 <= hws_s1;
    end
  end

  assign setup = psel && !penable && state == icp_pkg::ICP_IDLE;
  assign wr_en = psel && penable && pready && pwrite && pstrb[0];

  // Direction register; only bits 4 to 0 are stored.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir <= icp_pkg::DIR_RST[CW-1:0];
    end else if (hws_s2) begin
      dir <= icp_pkg::DIR_RST[CW-1:0];
    end else if (wr_en && paddr == icp_pkg::DIR_ADDR) begin
      dir <= pwdata[CW-1:0];
    end
  end

  // Data register; software standby simply leaves it alone.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dat <= icp_pkg::DAT_RST[CW-1:0];
    end else if (hws_s2) begin
      dat <= icp_pkg::DAT_RST[CW-1:0];
    end else if (wr_en && paddr == icp_pkg::DAT_ADDR) begin
      dat <= pwdata[CW-1:0];
    end
  end

  assign dat_view = (dat & dir) | (csp_s2 & ~dir);

  always_comb begin
    next_prdata  = '0;
    next_pslverr = 1'b0;
    case (paddr)
      icp_pkg::LVL_ADDR: begin
        next_prdata[7:0] = lvl_s2;
      end
      icp_pkg::DIR_ADDR: begin
        next_prdata[7:0] = icp_pkg::DIR_RDBACK;
      end
      icp_pkg::DAT_ADDR: begin
        next_prdata[7:0] = icp_pkg::RSVD_ONES | {3'b000, dat_view};
      end
      default: begin
        next_pslverr = 1'b1;
      end
    endcase
  end

  // Every transfer is answered in the first access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state   <= icp_pkg::ICP_IDLE;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      case (state)
        icp_pkg::ICP_IDLE: begin
          if (setup) begin
            state   <= icp_pkg::ICP_ANSWER;
            pready  <= 1'b1;
            pslverr <= next_pslverr;
            prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
          end
        end
        icp_pkg::ICP_ANSWER: begin
          state   <= icp_pkg::ICP_IDLE;
          pready  <= 1'b0;
          pslverr <= 1'b0;
        end
        default: begin
          state  <= icp_pkg::ICP_IDLE;
          pready <= 1'b0;
        end
      endcase
    end
  end

  assign dram_any = |bus_ctl.dram_area_select;

  // Pin function selection for the bidirectional port.
  always_comb begin
    next_drive.out  = '0;
    next_drive.oe_n = '1;
    if (dir[icp_pkg::PIN_CS0]) begin
      next_drive.out[icp_pkg::PIN_CS0]  = bus_ctl.cs_n[0];
      next_drive.oe_n[icp_pkg::PIN_CS0] = 1'b0;
    end
    if (dir[icp_pkg::PIN_CS1]) begin
      next_drive.out[icp_pkg::PIN_CS1]  = bus_ctl.cs_n[1];
      next_drive.oe_n[icp_pkg::PIN_CS1] = 1'b0;
    end
    if (bus_ctl.dram_area_select[icp_pkg::DRAS_HI]) begin
      next_drive.out[icp_pkg::PIN_CS2]  = bus_ctl.row_strobe_n[0];
      next_drive.oe_n[icp_pkg::PIN_CS2] = 1'b0;
    end else if (dir[icp_pkg::PIN_CS2]) begin
      next_drive.out[icp_pkg::PIN_CS2]  = bus_ctl.cs_n[2];
      next_drive.oe_n[icp_pkg::PIN_CS2] = 1'b0;
    end
    if (dir[icp_pkg::PIN_CS3]) begin
      next_drive.out[icp_pkg::PIN_CS3]  = bus_ctl.cs_n[3];
      next_drive.oe_n[icp_pkg::PIN_CS3] = 1'b0;
      if (dram_any) begin
        next_drive.out[icp_pkg::PIN_CS3] = bus_ctl.row_strobe_n[1];
      end
    end
    if (bus_ctl.refresh_strobe_enable) begin
      next_drive.out[icp_pkg::PIN_REFRESH_STROBE_OUT]  = bus_ctl.refresh_strobe_out;
      next_drive.oe_n[icp_pkg::PIN_REFRESH_STROBE_OUT] = 1'b0;
    end else if (dir[icp_pkg::PIN_REFRESH_STROBE_OUT]) begin
      next_drive.out[icp_pkg::PIN_REFRESH_STROBE_OUT]  = dat[icp_pkg::PIN_REFRESH_STROBE_OUT];
      next_drive.oe_n[icp_pkg::PIN_REFRESH_STROBE_OUT] = 1'b0;
    end
  end

  // Pins held by the stored settings keep driving in software standby.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cs_port_drive.out  <= '0;
      cs_port_drive.oe_n <= '1;
    end else begin
      cs_port_drive <= next_drive;
    end
  end

  // Interrupt and trigger inputs look at the pad whatever the direction.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_request          <= '0;
      converter_trigger_in <= 1'b1;
    end else begin
      irq_request          <= interrupt_enable_bits
                              & ~csp_s2[icp_pkg::IRQ_W-1:0];
      converter_trigger_in <= csp_s2[icp_pkg::PIN_TRIG];
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_level_read: assert property (
    setup && !pwrite && paddr == icp_pkg::LVL_ADDR
    |=> pready && prdata == {24'h000000, $past(lvl_s2)})
    else $error("Input port read does not return pin levels.");

  a_level_nowrite: assert property (
    wr_en && paddr == icp_pkg::LVL_ADDR && !hws_s2
    |=> $stable(dir) && $stable(dat))
    else $error("Write to input port changed a register.");

  a_dir_ones: assert property (
    setup && !pwrite && paddr == icp_pkg::DIR_ADDR
    |=> prdata == 32'h000000ff)
    else $error("Direction register read is not all ones.");

  a_dir_store: assert property (
    wr_en && paddr == icp_pkg::DIR_ADDR && !hws_s2
    |=> dir == $past(pwdata[CW-1:0]))
    else $error("Direction write not stored.");

  a_cs0_drive: assert property (
    dir[icp_pkg::PIN_CS0]
    |=> !cs_port_drive.oe_n[icp_pkg::PIN_CS0]
        && cs_port_drive.out[icp_pkg::PIN_CS0] == $past(bus_ctl.cs_n[0]))
    else $error("Pin 4 does not carry chip select 0.");

  a_pin_input: assert property (
    !dir[icp_pkg::PIN_CS3] |=> cs_port_drive.oe_n[icp_pkg::PIN_CS3])
    else $error("Pin 1 driven while set as input.");

  a_standby_init: assert property (
    hws_s2 |=> dir == icp_pkg::DIR_RST[CW-1:0]
               && dat == icp_pkg::DAT_RST[CW-1:0] ##1 cs_port_drive.oe_n[1])
    else $error("Hardware standby did not reload registers.");

  a_refresh_pin: assert property (
    bus_ctl.refresh_strobe_enable
    |=> !cs_port_drive.oe_n[0]
        && cs_port_drive.out[0] == $past(bus_ctl.refresh_strobe_out))
    else $error("Refresh strobe not on pin 0.");

  a_gpio_pin0: assert property (
    !bus_ctl.refresh_strobe_enable && dir[0]
    |=> !cs_port_drive.oe_n[0] && cs_port_drive.out[0] == $past(dat[0]))
    else $error("Pin 0 does not drive stored data.");

  a_data_read: assert property (
    setup && !pwrite && paddr == icp_pkg::DAT_ADDR
    |=> prdata[7:5] == 3'b111
        && prdata[4:0] == $past((dat & dir) | (csp_s2 & ~dir)))
    else $error("Data register read mixes wrong sources.");

  a_irq_level: assert property (
    1'b1 |=> irq_request == $past(interrupt_enable_bits & ~csp_s2[3:0]))
    else $error("Interrupt request ignores pin or enable.");

  a_ras_pin2: assert property (
    bus_ctl.dram_area_select[icp_pkg::DRAS_HI]
    |=> !cs_port_drive.oe_n[2]
        && cs_port_drive.out[2] == $past(bus_ctl.row_strobe_n[0]))
    else $error("Row strobe not on pin 2.");

  a_unmapped_err: assert property (
    setup && paddr != icp_pkg::LVL_ADDR && paddr != icp_pkg::DIR_ADDR
    && paddr != icp_pkg::DAT_ADDR |=> pready && pslverr)
    else $error("Unmapped address not flagged.");

  a_dat_store: assert property (
    wr_en && paddr == icp_pkg::DAT_ADDR && !hws_s2
    |=> dat == $past(pwdata[CW-1:0]))
    else $error("Data write not stored.");

  a_cs1_drive: assert property (
    dir[icp_pkg::PIN_CS1]
    |=> !cs_port_drive.oe_n[icp_pkg::PIN_CS1]
        && cs_port_drive.out[icp_pkg::PIN_CS1] == $past(bus_ctl.cs_n[1]))
    else $error("Pin 3 does not carry chip select 1.");

  a_cs2_drive: assert property (
    dir[icp_pkg::PIN_CS2] && !bus_ctl.dram_area_select[icp_pkg::DRAS_HI]
    |=> !cs_port_drive.oe_n[icp_pkg::PIN_CS2]
        && cs_port_drive.out[icp_pkg::PIN_CS2] == $past(bus_ctl.cs_n[2]))
    else $error("Pin 2 does not carry chip select 2.");

  a_cs3_drive: assert property (
    dir[icp_pkg::PIN_CS3] && !dram_any
    |=> !cs_port_drive.oe_n[icp_pkg::PIN_CS3]
        && cs_port_drive.out[icp_pkg::PIN_CS3] == $past(bus_ctl.cs_n[3]))
    else $error("Pin 1 does not carry chip select 3.");

  a_ras_pin1: assert property (
    dir[icp_pkg::PIN_CS3] && dram_any
    |=> !cs_port_drive.oe_n[icp_pkg::PIN_CS3]
        && cs_port_drive.out[icp_pkg::PIN_CS3]
           == $past(bus_ctl.row_strobe_n[1]))
    else $error("Row strobe not on pin 1.");

  a_pin0_input: assert property (
    !bus_ctl.refresh_strobe_enable && !dir[icp_pkg::PIN_REFRESH_STROBE_OUT]
    |=> cs_port_drive.oe_n[icp_pkg::PIN_REFRESH_STROBE_OUT])
    else $error("Pin 0 driven while set as input.");

  a_pin4_input: assert property (
    !dir[icp_pkg::PIN_CS0] |=> cs_port_drive.oe_n[icp_pkg::PIN_CS0])
    else $error("Pin 4 driven while set as input.");

  a_trigger_pin: assert property (
    1'b1 |=> converter_trigger_in == $past(csp_s2[icp_pkg::PIN_TRIG]))
    else $error("Trigger input does not follow pin 3.");

  a_regs_kept: assert property (
    !hws_s2 && !wr_en |=> $stable(dir) && $stable(dat))
    else $error("Register changed without a write or standby.");

  a_ready_pulse: assert property (
    pready |=> !pready)
    else $error("Ready held longer than one cycle.");

  a_write_zero: assert property (
    setup && pwrite |=> pready && prdata == 32'h00000000)
    else $error("Write returned nonzero read data.");

  a_strb_ignored: assert property (
    psel && penable && pready && pwrite && !pstrb[0] && !hws_s2
    |=> $stable(dir) && $stable(dat))
    else $error("Write without low byte lane changed a register.");

  a_unmapped_quiet: assert property (
    wr_en && !hws_s2 && paddr != icp_pkg::DIR_ADDR
    && paddr != icp_pkg::DAT_ADDR |=> $stable(dir) && $stable(dat))
    else $error("Write to another address changed a register.");

  a_upper_zero: assert property (
    pready |-> prdata[31:8] == 24'h000000)
    else $error("Read data above the low byte not zero.");

  c_level_read: cover property (
    setup && !pwrite && paddr == icp_pkg::LVL_ADDR);
  c_dir_write: cover property (wr_en && paddr == icp_pkg::DIR_ADDR);
  c_refresh_on: cover property ($rose(bus_ctl.refresh_strobe_enable));
  c_irq_out: cover property (|irq_request && !cs_port_drive.oe_n[3]);
  c_ras_pin1: cover property (dram_any && dir[icp_pkg::PIN_CS3]);

endmodule

// file: dv/icp_pad_model.sv
/*
  Pad model for the five bidirectional port pins.
  Assumes the bench drives ext as the far-side level of each pin.
*/
`timescale 1ns/1ns
module icp_pad_model (
  input  wire icp_pkg::icp_pins_t drive,
  input  wire logic [4:0]         ext,
  output logic      [4:0]         pad
);
  // A pad shows the port's level while oe_n is low, else the far side.
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      pad[i] = drive.oe_n[i] ? ext[i] : drive.out[i];
    end
  end
endmodule

// file: dv/input_port_and_chip_select_port_bench.sv
/*
  Self-checking bench for the input port and chip-select port.
  Assumes the APB slave answers with one-cycle pready and 2-FF pin sync.
*/
`timescale 1ns/1ns
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module input_port_and_chip_select_port_bench;
  logic               pclk, presetn, psel, penable, pwrite;
  logic               pready, pslverr, hw_sb, trig, err;
  logic [21:0]        paddr;
  logic [31:0]        pwdata, prdata, rd;
  logic [3:0]         pstrb, ien, irq;
  logic [7:0]         lvl;
  logic [4:0]         ext, pad, dir, dat, xo;
  logic [15:0]        r;
  icp_pkg::icp_pins_t drv;
  icp_pkg::icp_ctl_t  ctl;
  int                 n_errors, n_tests;

  icp_ports icp_ports_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .level_pins_in(lvl), .cs_port_in(pad), .cs_port_drive(drv),
    .bus_ctl(ctl), .interrupt_enable_bits(ien), .hw_standby_in(hw_sb),
    .irq_request(irq), .converter_trigger_in(trig));
  icp_pad_model icp_pad_model_inst (.drive(drv), .ext(ext), .pad(pad));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  function automatic logic [31:0] exp_dat(input logic [4:0] d,
                                          input logic [4:0] m,
                                          input logic [4:0] p);
    return {24'h0, 3'b111, (d & m) | (p & ~m)};
  endfunction

  task automatic final_report;
    $display("errors=%0d tests=%0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [21:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_errors++;
      final_report();
    end
  endtask

  task automatic drive_ctl(input logic [4:0] e, input logic [3:0] c,
                           input logic [2:0] a, input logic en,
                           input logic ro);
    @(posedge pclk);
    ext <= e;
    ctl.cs_n <= c;
    ctl.dram_area_select <= a;
    ctl.refresh_strobe_enable <= en;
    ctl.refresh_strobe_out <= ro;
    repeat (6) @(posedge pclk);
  endtask

  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, hw_sb} = 4'h0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hf;
    lvl = 8'ha5;
    ext = 5'h0a;
    ien = 4'h0;
    ctl = '0;
    ctl.cs_n = 4'h5;
    ctl.row_strobe_n = 2'b01;
    r = 16'h3b2d;
    n_errors = 0;
    n_tests = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    `CHK(drv.oe_n, 5'h0f);
    `CHK(drv.out[4], ctl.cs_n[0]);
    apb(1'b0, icp_pkg::DAT_ADDR, 32'h0, 4'hf);
    `CHK(rd, exp_dat(5'h00, 5'h10, ext));
    for (int i = 0; i < 6; i++) begin
      r = lfsr(r);
      @(posedge pclk);
      lvl <= r[7:0];
      repeat (4) @(posedge pclk);
      apb(1'b1, icp_pkg::LVL_ADDR, {24'h0, ~r[7:0]}, 4'hf);
      apb(1'b0, icp_pkg::LVL_ADDR, 32'h0, 4'hf);
      `CHK(rd, {24'h0, r[7:0]});
    end
    for (int i = 0; i < 8; i++) begin
      r = lfsr(r);
      dir = r[4:0];
      dat = r[12:8];
      apb(1'b1, icp_pkg::DIR_ADDR, {24'h0, r[7:0]}, 4'hf);
      apb(1'b1, icp_pkg::DAT_ADDR, {24'h0, r[15:8]}, 4'hf);
      r = lfsr(r);
      drive_ctl(r[4:0], r[11:8], 3'b000, 1'b0, 1'b0);
      apb(1'b0, icp_pkg::DAT_ADDR, 32'h0, 4'hf);
      `CHK(rd, exp_dat(dat, dir, ext));
      `CHK(drv.oe_n, ~dir);
      xo = {ctl.cs_n[0], ctl.cs_n[1], ctl.cs_n[2], ctl.cs_n[3], dat[0]};
      `CHK(drv.out & dir, xo & dir);
      apb(1'b0, icp_pkg::DIR_ADDR, 32'h0, 4'hf);
      `CHK(rd, 32'hff);
    end
    apb(1'b1, icp_pkg::DAT_ADDR, 32'h1f, 4'he);
    apb(1'b0, icp_pkg::DAT_ADDR, 32'h0, 4'hf);
    `CHK(rd, exp_dat(dat, dir, ext));
    apb(1'b0, 22'h000100, 32'h0, 4'hf);
    `CHK(err, 1'b1);
    apb(1'b1, icp_pkg::DIR_ADDR, 32'h0, 4'hf);
    drive_ctl(ext, 4'hf, 3'b000, 1'b1, 1'b0);
    `CHK(drv.oe_n[0], 1'b0);
    drive_ctl(ext, 4'hf, 3'b000, 1'b1, 1'b1);
    `CHK(drv.out[0], 1'b1);
    drive_ctl(ext, 4'hf, 3'b000, 1'b0, 1'b1);
    `CHK(drv.oe_n[0], 1'b1);
    apb(1'b1, icp_pkg::DIR_ADDR, 32'h06, 4'hf);
    drive_ctl(ext, 4'h8, 3'b100, 1'b0, 1'b0);
    `CHK(drv.out[2:1], 2'b10);
    drive_ctl(ext, 4'h8, 3'b001, 1'b0, 1'b0);
    `CHK(drv.out[2:1], 2'b00);
    ctl.row_strobe_n <= 2'b10;
    drive_ctl(ext, 4'h8, 3'b100, 1'b0, 1'b0);
    `CHK(drv.out[2:1], 2'b01);
    apb(1'b1, icp_pkg::DIR_ADDR, 32'h1e, 4'hf);
    for (int i = 0; i < 6; i++) begin
      r = lfsr(r);
      @(posedge pclk);
      ien <= r[3:0];
      drive_ctl(r[8:4], r[12:9], 3'b000, 1'b0, 1'b0);
      xo = {ctl.cs_n[0], ctl.cs_n[1], ctl.cs_n[2], ctl.cs_n[3], ext[0]};
      `CHK(irq, ien & ~xo[3:0]);
      `CHK(trig, xo[3]);
    end
    repeat (20) @(posedge pclk);
    `CHK(drv.oe_n, 5'h01);
    apb(1'b1, icp_pkg::DAT_ADDR, 32'h1f, 4'hf);
    @(posedge pclk);
    hw_sb <= 1'b1;
    repeat (6) @(posedge pclk);
    hw_sb <= 1'b0;
    repeat (6) @(posedge pclk);
    `CHK(drv.oe_n, 5'h0f);
    apb(1'b0, icp_pkg::DAT_ADDR, 32'h0, 4'hf);
    `CHK(rd, exp_dat(5'h00, 5'h10, ext));
    final_report();
  end
endmodule
